/* bssmw_params.svh */
`ifndef BSSMW_PARAMS_SVH
`define BSSMW_PARAMS_SVH
// ---------------------------------------------------------------
// configuration offsets (byte addresses)
// ---------------------------------------------------------------
`define BSSMW_OFS_STATUS 8'h1E
`define BSSMW_OFS_BASE 8'h20
`define BSSMW_OFS_LIMIT 8'h22
// ---------------------------------------------------------------
// status field positions
// ---------------------------------------------------------------
`define BSSMW_BIT_INIT_ABORT 13
`define BSSMW_BIT_RESP_ABORT_RCV 12
`define BSSMW_BIT_RESP_ABORT_SIG 11
`define BSSMW_BIT_PARITY 8
`define BSSMW_STICKY_MASK 16'h3900
`define BSSMW_STATUS_FIXED 16'h02A0
`define BSSMW_FIXED_MASK 16'h06FF
`define BSSMW_RSVD_MASK 16'h005F
`define BSSMW_SYNC_RESET 7'h00
// ---------------------------------------------------------------
// window fields
// ---------------------------------------------------------------
`define BSSMW_WIN_MASK 16'hFFF0
`define BSSMW_WIN_RESET 16'h0000
`define BSSMW_LOW_FILL 20'h00000
`define BSSMW_HIGH_FILL 20'hFFFFF
`endif

/* bssmw_pkg.sv */
package bssmw_pkg;
  typedef logic [15:0] bssmw_reg_t;
  typedef logic [31:0] bssmw_addr_t;
endpackage : bssmw_pkg

/* bssmw_status.sv */
`timescale 1ns/10ps
`include "bssmw_params.svh"
module bssmw_status (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // software clear
  input wire logic clr_en_i,
  input wire logic [15:0] clr_data_i,
  // events
  input wire logic [15:0] set_i,
  // state
  output bssmw_pkg::bssmw_reg_t status_o
);
  logic [15:0] flags_q;
  logic [15:0] flags_d;
  logic [15:0] clr_mask;

  // set wins over a clear in the same cycle
  assign clr_mask = clr_en_i ? clr_data_i : 16'h0000;
  assign flags_d = ((flags_q & ~clr_mask) | set_i)
                   & `BSSMW_STICKY_MASK;
  assign status_o = flags_q | `BSSMW_STATUS_FIXED;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      flags_q <= 16'h0000;
    end else begin
      flags_q <= flags_d;
    end
  end

  a_sticky_hold: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (flags_q[`BSSMW_BIT_INIT_ABORT] && !set_i[`BSSMW_BIT_INIT_ABORT]
     && !(clr_en_i && clr_data_i[`BSSMW_BIT_INIT_ABORT]))
    |=> flags_q[`BSSMW_BIT_INIT_ABORT])
    else $error("sticky flag lost");
  a_clear_one: assert property (@(posedge ref_clk_i) disable iff (!resetn_i)
    (clr_en_i && clr_data_i[`BSSMW_BIT_PARITY]
     && !set_i[`BSSMW_BIT_PARITY]) |=> !flags_q[`BSSMW_BIT_PARITY])
    else $error("write one did not clear");
endmodule : bssmw_status

/* bssmw_window.sv */
`timescale 1ns/10ps
`include "bssmw_params.svh"
module bssmw_window (
  // window registers
  input wire logic [15:0] base_i,
  input wire logic [15:0] limit_i,
  // request
  input wire logic [31:0] addr_i,
  // decision
  output logic hit_o
);
  bssmw_pkg::bssmw_addr_t low_bound;
  bssmw_pkg::bssmw_addr_t high_bound;

  assign low_bound = {base_i[15:4], `BSSMW_LOW_FILL};
  assign high_bound = {limit_i[15:4], `BSSMW_HIGH_FILL};
  // base above limit leaves no address in range
  assign hit_o = (addr_i >= low_bound) && (addr_i <= high_bound);
endmodule : bssmw_window

/* bssmw_top.sv */
// Overview of operation
// - initiator abort on downstream bus sets status bit 13.
// - abort received from addressed target sets status bit 12.
// - abort signaled as responder sets status bit 11.
// - status bits 10:9 read-only, always 01b.
// - bit 8 set on master parity error when parity response enabled.
// - status bit 7 read-only one, back-to-back capable.
// - status bit 5 read-only one, fast clock capable.
// - status bits 6 and 4:0 ignore writes, read zero.
// - base bits 15:4 writable, give address 31:20, low bits zero.
// - limit bits 15:4 writable, give address 31:20, low bits ones.
// - base and limit bits 3:0 read zero regardless of writes.
// - base bound is lower end of downstream forward range.
// - limit bound is upper end of downstream forward range.
// - abort and parity flags sticky until software clears them.
`timescale 1ns/10ps
`include "bssmw_params.svh"
module bssmw_top (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  // configuration access
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [15:0] cfg_wdata_i,
  input wire logic [1:0] cfg_be_i,
  output logic [15:0] cfg_rdata_o,
  // downstream bus events
  input wire logic initiator_abort_seen_i,
  input wire logic responder_abort_received_i,
  input wire logic responder_abort_signaled_i,
  input wire logic bus_master_i,
  input wire logic parity_response_enable_i,
  input wire logic read_perr_driven_i,
  input wire logic write_perr_seen_i,
  // forwarding decision
  input wire logic [31:0] fwd_addr_i,
  output logic fwd_hit_o
);
  bssmw_pkg::bssmw_reg_t window_low_bound_q;
  bssmw_pkg::bssmw_reg_t window_high_bound_q;
  bssmw_pkg::bssmw_reg_t status;
  logic [15:0] rdata_q;
  logic [15:0] set_vec;
  logic [15:0] be_mask;
  logic initiator_parity_fault;
  logic sel_status;
  logic sel_base;
  logic sel_limit;
  logic [15:0] rd_mux;
  logic [15:0] low_d;
  logic [15:0] high_d;

  // ---------------------------------------------------------------
  // decode
  // ---------------------------------------------------------------
  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  function automatic logic [15:0] merge(input logic [15:0] old_v,
                                        input logic [15:0] new_v,
                                        input logic [15:0] m);
    merge = ((old_v & ~m) | (new_v & m)) & `BSSMW_WIN_MASK;
  endfunction : merge

  assign be_mask = lane_mask(cfg_be_i);
  assign sel_status = (cfg_addr_i == `BSSMW_OFS_STATUS);
  assign sel_base = (cfg_addr_i == `BSSMW_OFS_BASE);
  assign sel_limit = (cfg_addr_i == `BSSMW_OFS_LIMIT);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [6:0] pin_raw;
  logic [6:0] pin_s1_q;
  logic [6:0] pin_s2_q;
  logic abort_seen_s;
  logic abort_recv_s;
  logic abort_sig_s;
  logic master_s;
  logic parity_response_enable_s;
  logic perr_rd_s;
  logic perr_wr_s;

  assign pin_raw = {write_perr_seen_i,
                    read_perr_driven_i,
                    parity_response_enable_i,
                    bus_master_i,
                    responder_abort_signaled_i,
                    responder_abort_received_i,
                    initiator_abort_seen_i};

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      pin_s1_q <= `BSSMW_SYNC_RESET;
      pin_s2_q <= `BSSMW_SYNC_RESET;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign {perr_wr_s,
          perr_rd_s,
          parity_response_enable_s,
          master_s,
          abort_sig_s,
          abort_recv_s,
          abort_seen_s} = pin_s2_q;

  // ---------------------------------------------------------------
  // events
  // ---------------------------------------------------------------
  assign initiator_parity_fault = master_s && parity_response_enable_s
    && (perr_rd_s || perr_wr_s);

  always_comb begin
    set_vec = 16'h0000;
    set_vec[`BSSMW_BIT_INIT_ABORT] = abort_seen_s;
    set_vec[`BSSMW_BIT_RESP_ABORT_RCV] = abort_recv_s;
    set_vec[`BSSMW_BIT_RESP_ABORT_SIG] = abort_sig_s;
    set_vec[`BSSMW_BIT_PARITY] = initiator_parity_fault;
  end

  // fixed bits 10:9=01, 7=1, 5=1; reserved zero
  bssmw_status u_status (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .clr_en_i(cfg_wr_i && sel_status),
    .clr_data_i(cfg_wdata_i & be_mask),
    .set_i(set_vec),
    .status_o(status)
  );

  // ---------------------------------------------------------------
  // window registers
  // ---------------------------------------------------------------
  assign low_d = (cfg_wr_i && sel_base)
    ? merge(window_low_bound_q, cfg_wdata_i, be_mask)
    : window_low_bound_q;
  assign high_d = (cfg_wr_i && sel_limit)
    ? merge(window_high_bound_q, cfg_wdata_i, be_mask)
    : window_high_bound_q;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      window_low_bound_q <= `BSSMW_WIN_RESET;
      window_high_bound_q <= `BSSMW_WIN_RESET;
    end else begin
      window_low_bound_q <= low_d;
      window_high_bound_q <= high_d;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  assign rd_mux = sel_status ? status
    : sel_base ? window_low_bound_q
    : sel_limit ? window_high_bound_q
    : 16'h0000;

  always_ff @(posedge ref_clk_i) begin
    if (!resetn_i) begin
      rdata_q <= 16'h0000;
    end else if (cfg_rd_i) begin
      rdata_q <= rd_mux;
    end
  end
  assign cfg_rdata_o = rdata_q;

  // ---------------------------------------------------------------
  // forwarding window
  // ---------------------------------------------------------------
  bssmw_window u_window (
    .base_i(window_low_bound_q),
    .limit_i(window_high_bound_q),
    .addr_i(fwd_addr_i),
    .hit_o(fwd_hit_o)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_abort_clear;
    cfg_wr_i && sel_status && cfg_be_i[1]
    && cfg_wdata_i[`BSSMW_BIT_INIT_ABORT] && !abort_seen_s;
  endsequence

  sequence s_parity_event;
    master_s && parity_response_enable_s && (perr_rd_s || perr_wr_s);
  endsequence

  a_master_abort_set: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    abort_seen_s
    |=>
    status[`BSSMW_BIT_INIT_ABORT])
    else $error("bit 13 not set");

  a_recv_abort_set: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    abort_recv_s
    |=>
    status[`BSSMW_BIT_RESP_ABORT_RCV])
    else $error("bit 12 not set");

  a_sig_abort_set: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    abort_sig_s
    |=>
    status[`BSSMW_BIT_RESP_ABORT_SIG])
    else $error("bit 11 not set");

  a_parity_gate: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    (!status[`BSSMW_BIT_PARITY] && !parity_response_enable_s)
    |=>
    !status[`BSSMW_BIT_PARITY])
    else $error("parity flag set while disabled");

  a_parity_set: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    s_parity_event
    |=>
    status[`BSSMW_BIT_PARITY])
    else $error("parity flag not set");

  a_fixed_bits: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    (status & `BSSMW_FIXED_MASK)
    == `BSSMW_STATUS_FIXED)
    else $error("fixed status bits wrong");

  a_low_nibble: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    (window_low_bound_q[3:0] == 4'h0)
    && (window_high_bound_q[3:0] == 4'h0))
    else $error("window low nibble nonzero");

  a_base_write: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    (cfg_wr_i && sel_base && cfg_be_i == 2'h3)
    |=>
    window_low_bound_q == ($past(cfg_wdata_i) & `BSSMW_WIN_MASK))
    else $error("base write lost");

  a_limit_write: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    (cfg_wr_i && sel_limit && cfg_be_i == 2'h3)
    |=>
    window_high_bound_q == ($past(cfg_wdata_i) & `BSSMW_WIN_MASK))
    else $error("limit write lost");

  a_window_hit: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    fwd_hit_o == ((fwd_addr_i[31:20] >= window_low_bound_q[15:4])
    && (fwd_addr_i[31:20] <= window_high_bound_q[15:4])))
    else $error("window decision wrong");

  a_low_edge_hit: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    (fwd_addr_i == {window_low_bound_q[15:4], `BSSMW_LOW_FILL})
    && (window_low_bound_q[15:4] <= window_high_bound_q[15:4])
    |-> fwd_hit_o)
    else $error("lowest window address missed");

  a_high_edge_hit: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    (fwd_addr_i == {window_high_bound_q[15:4], `BSSMW_HIGH_FILL})
    && (window_low_bound_q[15:4] <= window_high_bound_q[15:4])
    |-> fwd_hit_o)
    else $error("highest window address missed");

  a_read_status: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    (cfg_rd_i && sel_status)
    |=>
    cfg_rdata_o[10:9] == 2'h1)
    else $error("status read wrong");

  a_read_reserved: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    (cfg_rd_i && sel_status)
    |=>
    (cfg_rdata_o & `BSSMW_RSVD_MASK) == 16'h0000)
    else $error("reserved status bits nonzero");

  a_unmapped_read: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    (cfg_rd_i && !sel_status && !sel_base && !sel_limit)
    |=>
    cfg_rdata_o == 16'h0000)
    else $error("unmapped read nonzero");

  a_abort_clear: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    s_abort_clear
    |=>
    !status[`BSSMW_BIT_INIT_ABORT])
    else $error("abort flag not cleared");

  a_parity_clear: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    (cfg_wr_i && sel_status && cfg_be_i[1]
    && cfg_wdata_i[`BSSMW_BIT_PARITY] && !initiator_parity_fault)
    |=> !status[`BSSMW_BIT_PARITY])
    else $error("parity flag not cleared");

  a_rdata_hold: assert property (@(posedge ref_clk_i)
    disable iff (!resetn_i)
    !cfg_rd_i
    |=>
    $stable(cfg_rdata_o))
    else $error("read data changed without read");
endmodule : bssmw_top

/* bssmw_agent.sv */
`timescale 1ns/10ps
// ----------------------------------------
// secondary bus agents
// ----------------------------------------
module bssmw_agent (
  // clock
  input wire logic ref_clk_i,
  // events and qualifiers toward the bridge
  output logic [4:0] ev_o,
  output logic master_o,
  output logic parity_en_o
);
  initial begin
    ev_o = 5'h00;
    master_o = 1'b0;
    parity_en_o = 1'b0;
  end
  // bus ownership and parity response level
  task mode(input logic m, input logic e);
    master_o = m;
    parity_en_o = e;
  endtask : mode
  // one-cycle event, then three quiet cycles
  task pulse(input logic [4:0] m);
    ev_o = m;
    @(negedge ref_clk_i);
    ev_o = 5'h00;
    @(negedge ref_clk_i);
    repeat (2) @(negedge ref_clk_i);
  endtask : pulse
endmodule : bssmw_agent

/* tb.sv */
`timescale 1ns/10ps
module tb;
  typedef struct {
    logic [15:0] b;
    logic [15:0] l;
    logic [31:0] a;
    logic h;
  } bssmw_row_t;
  logic ref_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic cfg_wr_i = 1'b0;
  logic cfg_rd_i = 1'b0;
  logic [7:0] cfg_addr_i = 8'h00;
  logic [15:0] cfg_wdata_i = 16'h0000;
  logic [1:0] cfg_be_i = 2'h3;
  logic [31:0] fwd_addr_i = 32'h00000000;
  logic [15:0] cfg_rdata_o;
  logic fwd_hit_o;
  logic [4:0] ev;
  logic master;
  logic pen;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  bssmw_row_t win[7] = '{
    '{16'h0000, 16'h0000, 32'h000FFFFF, 1'b1},
    '{16'h0000, 16'h0000, 32'h00100000, 1'b0},
    '{16'h123F, 16'h456F, 32'h12300000, 1'b1},
    '{16'h1230, 16'h4560, 32'h122FFFFF, 1'b0},
    '{16'h1230, 16'h4560, 32'h456FFFFF, 1'b1},
    '{16'h1230, 16'h4560, 32'h45700000, 1'b0},
    '{16'h5000, 16'h4000, 32'h45000000, 1'b0}};
  logic [4:0] evm[5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
  logic [15:0] evb[5] = '{16'h2000, 16'h1000, 16'h0800, 16'h0100, 16'h0100};
  always #5 ref_clk_i = ~ref_clk_i;
  bssmw_agent agent (.ref_clk_i(ref_clk_i), .ev_o(ev), .master_o(master),
    .parity_en_o(pen));
  bssmw_top uut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
    .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_be_i(cfg_be_i),
    .cfg_rdata_o(cfg_rdata_o), .initiator_abort_seen_i(ev[0]),
    .responder_abort_received_i(ev[1]), .responder_abort_signaled_i(ev[2]),
    .bus_master_i(master), .parity_response_enable_i(pen),
    .read_perr_driven_i(ev[3]), .write_perr_seen_i(ev[4]),
    .fwd_addr_i(fwd_addr_i), .fwd_hit_o(fwd_hit_o));
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task test_done;
    if (fails == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : test_done
  task wr(input logic [7:0] a, input logic [15:0] d, input logic [1:0] be);
    cfg_wr_i = 1'b1;
    cfg_addr_i = a;
    cfg_wdata_i = d;
    cfg_be_i = be;
    @(negedge ref_clk_i);
    cfg_wr_i = 1'b0;
    @(negedge ref_clk_i);
  endtask : wr
  task rd(input logic [7:0] a, input logic [15:0] e);
    cfg_rd_i = 1'b1;
    cfg_addr_i = a;
    @(negedge ref_clk_i);
    cfg_rd_i = 1'b0;
    @(negedge ref_clk_i);
    chk("rdata", cfg_rdata_o, e);
  endtask : rd
  always @(posedge ref_clk_i) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      test_done();
    end
  end
  initial begin
    repeat (3) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    rd(8'h1E, 16'h02A0);
    foreach (win[i]) begin
      wr(8'h20, win[i].b, 2'h3);
      wr(8'h22, win[i].l, 2'h3);
      rd(8'h20, win[i].b & 16'hFFF0);
      rd(8'h22, win[i].l & 16'hFFF0);
      fwd_addr_i = win[i].a;
      @(negedge ref_clk_i);
      chk("hit", fwd_hit_o, win[i].h);
    end
    agent.mode(1'b1, 1'b1);
    for (int i = 0; i < 5; i++) begin
      agent.pulse(evm[i]);
      rd(8'h1E, 16'h02A0 | evb[i]);
      wr(8'h1E, evb[i], 2'h3);
      rd(8'h1E, 16'h02A0);
    end
    agent.mode(1'b1, 1'b0);
    agent.pulse(5'h18);
    rd(8'h1E, 16'h02A0);
    agent.mode(1'b0, 1'b1);
    agent.pulse(5'h18);
    rd(8'h1E, 16'h02A0);
    agent.mode(1'b1, 1'b1);
    agent.pulse(5'h0F);
    repeat (5) @(negedge ref_clk_i);
    rd(8'h1E, 16'h3BA0);
    wr(8'h1E, 16'h2000, 2'h3);
    rd(8'h1E, 16'h1BA0);
    wr(8'h1E, 16'hFFFF, 2'h3);
    rd(8'h1E, 16'h02A0);
    wr(8'h20, 16'hFFF0, 2'h3);
    wr(8'h20, 16'h0000, 2'h1);
    rd(8'h20, 16'hFF00);
    wr(8'h30, 16'hFFFF, 2'h3);
    rd(8'h30, 16'h0000);
    agent.pulse(5'h01);
    resetn_i = 1'b0;
    repeat (3) @(negedge ref_clk_i);
    resetn_i = 1'b1;
    rd(8'h1E, 16'h02A0);
    rd(8'h20, 16'h0000);
    test_done();
  end
endmodule : tb
